// *** bififo_defines.svh ***
// Purpose: shared constants for the bidirectional fifo flag, mailbox and sizing logic
// Assumes: included by the package and the top module
// Notes:   widths are in bits of the port data buses
`ifndef BIFIFO_DEFINES_SVH
`define BIFIFO_DEFINES_SVH

`define DATA_W        36
`define WORD_W        18
`define BYTE_W        9
`define SHIFT_W       6
`define PHASE_W       2
`define LAST_LONG     2'h0
`define LAST_WORD     2'h1
`define LAST_BYTE     2'h3
`define OFFSET_PRESET 8

`endif

// *** bififo_pkg.sv ***
// Purpose: types shared by the bidirectional fifo logic
// Assumes: bififo_defines.svh supplies the widths
// Notes:   pin bundles are synchronised as one vector
`include "bififo_defines.svh"

package bififo_pkg;

  typedef enum logic [1:0] {
    WIDTH_LONG = 2'b00,
    WIDTH_WORD = 2'b01,
    WIDTH_BYTE = 2'b10
  } bus_width_t;

  typedef struct packed {
    logic               clk;
    logic               select_n;
    logic               dir;
    logic               en;
    logic               mail_sel;
    logic [`DATA_W-1:0] data;
  } port_pins_t;

  typedef struct packed {
    logic width_match;
    logic size;
    logic msb_first;
    logic mr1_n;
    logic mr2_n;
  } config_pins_t;

  typedef struct packed {
    port_pins_t   a;
    port_pins_t   b;
    config_pins_t cfg;
  } pin_bundle_t;

endpackage

// *** bififo_core.sv ***
// Purpose: flags, mailboxes and port b bus sizing of a two-direction 36-bit fifo pair
// Assumes: port clocks and pins are slow against clock and are oversampled
// Notes:   port clock edges are detected on clock; offsets load with presets at reset
//
// Functional notes
// - almost-empty flag made on reading port edges from write and read pointers
// - almost-empty low at X words or fewer, high at X+1; output register uncounted
// - port b almost-empty uses empty_offset_1, port a uses empty_offset_2
// - almost-empty rises on second reading-port edge after the filling write
// - an edge too close to the event may push the count one edge later
// - almost-full flag made on writing port edges from both pointers
// - almost-full low at depth minus Y or more, high at depth minus Y+1 or less
// - port a almost-full uses full_offset_1, port b uses full_offset_2
// - almost-full rises on second writing-port edge after the draining read
// - each direction has a 36-bit mail register chosen by the port mail select
// - a-to-b mail loads on port a write with mail select; lanes follow b size
// - b-to-a mail loads on port b write with mail select; unused lanes ignored
// - mail write drives its full flag low; later writes ignored while low
// - port output shows fifo register or mail register by its mail select
// - port b mail read sets a-to-b mail flag high; data on sized lanes
// - port a mail read sets b-to-a mail flag high; data on sized lanes
// - mail reads keep contents; endian order never touches mail data
// - port b fifo width 36, 18 or 9 by the size and match inputs, held static
// - size and endian selections take effect when master reset completes
// - endian level sampled on master reset release; high means msb first
// - memories hold long words; sizing only after fifo1 read, before fifo2 write
// - narrow fifo1 reads give the first piece, later reads give the rest
// - narrow fifo2 writes collect pieces; last piece commits the long word
`timescale 1ns/1ps
`include "bififo_defines.svh"

module bififo_core #(
  parameter int                ADDR_W       = 8,
  parameter logic [ADDR_W-1:0] EMPTY_PRESET = ADDR_W'(`OFFSET_PRESET),
  parameter logic [ADDR_W-1:0] FULL_PRESET  = ADDR_W'(`OFFSET_PRESET)
) (
  // system
  input  wire logic               clock,
  input  wire logic               rst,
  // port a pins
  input  wire logic               port_a_clk,
  input  wire logic               port_a_select_n,
  input  wire logic               port_a_write_not_read,
  input  wire logic               port_a_transfer_en,
  input  wire logic               port_a_mail_sel,
  input  wire logic [`DATA_W-1:0] port_a_data_in,
  output logic      [`DATA_W-1:0] port_a_data_out,
  output logic                    port_a_data_oe,
  // port b pins
  input  wire logic               port_b_clk,
  input  wire logic               port_b_select_n,
  input  wire logic               port_b_read_not_write,
  input  wire logic               port_b_transfer_en,
  input  wire logic               port_b_mail_sel,
  input  wire logic [`DATA_W-1:0] port_b_data_in,
  output logic      [`DATA_W-1:0] port_b_data_out,
  output logic                    port_b_data_oe,
  // configuration and resets
  input  wire logic               width_match_sel,
  input  wire logic               size_sel,
  input  wire logic               msb_first_sel,
  input  wire logic               master_reset_1_n,
  input  wire logic               master_reset_2_n,
  // flags
  output logic                    port_a_near_empty_n,
  output logic                    port_a_near_full_n,
  output logic                    port_b_near_empty_n,
  output logic                    port_b_near_full_n,
  output logic                    mail_ab_full_n,
  output logic                    mail_ba_full_n
);

  localparam int              PW        = ADDR_W + 1;
  localparam int              DEPTH     = 1 << ADDR_W;
  localparam logic [PW-1:0]   DEPTH_CNT = {1'b1, {ADDR_W{1'b0}}};

  function automatic bififo_pkg::bus_width_t decode_width(input logic match, input logic size);
    if (!match) begin
      return bififo_pkg::WIDTH_LONG;
    end else if (!size) begin
      return bififo_pkg::WIDTH_WORD;
    end else begin
      return bififo_pkg::WIDTH_BYTE;
    end
  endfunction

  function automatic logic [`DATA_W-1:0] lane_mask(input bififo_pkg::bus_width_t w);
    case (w)
      bififo_pkg::WIDTH_WORD: return {{(`DATA_W-`WORD_W){1'b0}}, {`WORD_W{1'b1}}};
      bififo_pkg::WIDTH_BYTE: return {{(`DATA_W-`BYTE_W){1'b0}}, {`BYTE_W{1'b1}}};
      default:                return {`DATA_W{1'b1}};
    endcase
  endfunction

  function automatic logic [`PHASE_W-1:0] last_phase(input bififo_pkg::bus_width_t w);
    case (w)
      bififo_pkg::WIDTH_WORD: return `LAST_WORD;
      bififo_pkg::WIDTH_BYTE: return `LAST_BYTE;
      default:                return `LAST_LONG;
    endcase
  endfunction

  // lane of the piece moved in a given phase: msb first walks down from the top
  function automatic logic [`SHIFT_W-1:0] piece_shift(input bififo_pkg::bus_width_t w,
                                                       input logic msb_first,
                                                       input logic [`PHASE_W-1:0] phase);
    logic [`PHASE_W-1:0] lane;
    lane = msb_first ? last_phase(w) - phase : phase;
    case (w)
      bififo_pkg::WIDTH_WORD: return `SHIFT_W'(lane * `WORD_W);
      bififo_pkg::WIDTH_BYTE: return `SHIFT_W'(lane * `BYTE_W);
      default:                return `SHIFT_W'(0);
    endcase
  endfunction

  // pin sampling: three flops, a bit changes once stages two and three agree
  bififo_pkg::pin_bundle_t pins_in;
  bififo_pkg::pin_bundle_t s1_reg;
  bififo_pkg::pin_bundle_t s2_reg;
  bififo_pkg::pin_bundle_t s3_reg;
  bififo_pkg::pin_bundle_t st_reg;
  bififo_pkg::pin_bundle_t prev_reg;

  assign pins_in = '{
    a: '{clk: port_a_clk, select_n: port_a_select_n, dir: port_a_write_not_read,
         en: port_a_transfer_en, mail_sel: port_a_mail_sel, data: port_a_data_in},
    b: '{clk: port_b_clk, select_n: port_b_select_n, dir: port_b_read_not_write,
         en: port_b_transfer_en, mail_sel: port_b_mail_sel, data: port_b_data_in},
    cfg: '{width_match: width_match_sel, size: size_sel, msb_first: msb_first_sel,
           mr1_n: master_reset_1_n, mr2_n: master_reset_2_n}
  };

  always_ff @(posedge clock) begin
    if (rst) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      st_reg   <= '0;
      prev_reg <= '0;
    end else begin
      s1_reg   <= pins_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      st_reg   <= bififo_pkg::pin_bundle_t'((s2_reg & ~(s2_reg ^ s3_reg))
                                            | (st_reg & (s2_reg ^ s3_reg)));
      prev_reg <= st_reg;
    end
  end

  logic a_edge, b_edge, a_wr, a_rd, b_wr, b_rd, mr1_rel, mr2_rel, in_reset1, in_reset2;

  assign a_edge    = st_reg.a.clk & ~prev_reg.a.clk;
  assign b_edge    = st_reg.b.clk & ~prev_reg.b.clk;
  assign a_wr      = a_edge & ~st_reg.a.select_n & st_reg.a.en & st_reg.a.dir;
  assign a_rd      = a_edge & ~st_reg.a.select_n & st_reg.a.en & ~st_reg.a.dir;
  assign b_rd      = b_edge & ~st_reg.b.select_n & st_reg.b.en & st_reg.b.dir;
  assign b_wr      = b_edge & ~st_reg.b.select_n & st_reg.b.en & ~st_reg.b.dir;
  assign mr1_rel   = st_reg.cfg.mr1_n & ~prev_reg.cfg.mr1_n;
  assign mr2_rel   = st_reg.cfg.mr2_n & ~prev_reg.cfg.mr2_n;
  assign in_reset1 = ~st_reg.cfg.mr1_n;
  assign in_reset2 = ~st_reg.cfg.mr2_n;

  // configuration latched at master reset release; pins must be static meanwhile
  bififo_pkg::bus_width_t width_reg;
  logic                   msb_first_reg;
  logic [ADDR_W-1:0]      empty_offset_1_reg, empty_offset_2_reg;
  logic [ADDR_W-1:0]      full_offset_1_reg, full_offset_2_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      width_reg     <= bififo_pkg::WIDTH_LONG;
      msb_first_reg <= 1'b0;
    end else if (mr1_rel || mr2_rel) begin
      width_reg     <= decode_width(st_reg.cfg.width_match, st_reg.cfg.size);
      msb_first_reg <= st_reg.cfg.msb_first;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || in_reset1) begin
      empty_offset_1_reg <= EMPTY_PRESET;
      full_offset_1_reg  <= FULL_PRESET;
    end
    if (rst || in_reset2) begin
      empty_offset_2_reg <= EMPTY_PRESET;
      full_offset_2_reg  <= FULL_PRESET;
    end
  end

  // fifo1: port a writes long words, port b reads in sized pieces
  logic [`DATA_W-1:0]  mem1 [DEPTH];
  logic [PW-1:0]       w1_ptr_reg, r1_ptr_reg, w1_at_b_reg, r1_at_a_reg;
  logic [`DATA_W-1:0]  aux1_reg, fifo1_out_reg;
  logic [`PHASE_W-1:0] phase1_reg;
  logic                push1, pop1, full1, empty1;

  // the synchronised copies lag, so full and empty err on the safe side
  assign full1  = (w1_ptr_reg - r1_at_a_reg) == DEPTH_CNT;
  assign empty1 = w1_at_b_reg == r1_ptr_reg;
  assign push1  = a_wr & ~st_reg.a.mail_sel & ~full1 & ~in_reset1;
  assign pop1   = b_rd & ~st_reg.b.mail_sel & ~in_reset1 & (phase1_reg == '0) & ~empty1;

  always_ff @(posedge clock) begin
    if (push1) begin
      mem1[w1_ptr_reg[ADDR_W-1:0]] <= st_reg.a.data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || in_reset1) begin
      w1_ptr_reg  <= '0;
      r1_ptr_reg  <= '0;
      w1_at_b_reg <= '0;
      r1_at_a_reg <= '0;
      phase1_reg  <= '0;
      aux1_reg    <= '0;
      fifo1_out_reg <= '0;
    end else begin
      if (push1) begin
        w1_ptr_reg <= w1_ptr_reg + PW'(1);
      end
      if (a_edge) begin
        r1_at_a_reg <= r1_ptr_reg;
      end
      if (b_edge) begin
        w1_at_b_reg <= w1_ptr_reg;
      end
      if (pop1) begin
        r1_ptr_reg    <= r1_ptr_reg + PW'(1);
        aux1_reg      <= mem1[r1_ptr_reg[ADDR_W-1:0]];
        fifo1_out_reg <= (mem1[r1_ptr_reg[ADDR_W-1:0]]
                          >> piece_shift(width_reg, msb_first_reg, '0))
                         & lane_mask(width_reg);
        phase1_reg    <= (last_phase(width_reg) == '0) ? '0 : `PHASE_W'(1);
      end else if (b_rd && !st_reg.b.mail_sel && phase1_reg != '0) begin
        fifo1_out_reg <= (aux1_reg >> piece_shift(width_reg, msb_first_reg, phase1_reg))
                         & lane_mask(width_reg);
        phase1_reg    <= (phase1_reg == last_phase(width_reg)) ? '0 : phase1_reg + `PHASE_W'(1);
      end
    end
  end

  // fifo2: port b writes sized pieces, port a reads long words
  logic [`DATA_W-1:0]  mem2 [DEPTH];
  logic [PW-1:0]       w2_ptr_reg, r2_ptr_reg, w2_at_a_reg, r2_at_b_reg;
  logic [`DATA_W-1:0]  aux2_reg, fifo2_out_reg, piece2;
  logic [`PHASE_W-1:0] phase2_reg;
  logic                take2, push2, pop2, full2, empty2;

  assign full2  = (w2_ptr_reg - r2_at_b_reg) == DEPTH_CNT;
  assign empty2 = w2_at_a_reg == r2_ptr_reg;
  assign take2  = b_wr & ~st_reg.b.mail_sel & ~full2 & ~in_reset2;
  assign push2  = take2 & (phase2_reg == last_phase(width_reg));
  assign pop2   = a_rd & ~st_reg.a.mail_sel & ~empty2 & ~in_reset2;
  assign piece2 = (st_reg.b.data & lane_mask(width_reg))
                  << piece_shift(width_reg, msb_first_reg, phase2_reg);

  always_ff @(posedge clock) begin
    if (push2) begin
      mem2[w2_ptr_reg[ADDR_W-1:0]] <= (phase2_reg == '0) ? piece2 : (aux2_reg | piece2);
    end
  end

  always_ff @(posedge clock) begin
    if (rst || in_reset2) begin
      w2_ptr_reg    <= '0;
      r2_ptr_reg    <= '0;
      w2_at_a_reg   <= '0;
      r2_at_b_reg   <= '0;
      phase2_reg    <= '0;
      aux2_reg      <= '0;
      fifo2_out_reg <= '0;
    end else begin
      if (take2) begin
        aux2_reg   <= (phase2_reg == '0) ? piece2 : (aux2_reg | piece2);
        phase2_reg <= push2 ? '0 : phase2_reg + `PHASE_W'(1);
      end
      if (push2) begin
        w2_ptr_reg <= w2_ptr_reg + PW'(1);
      end
      if (pop2) begin
        r2_ptr_reg    <= r2_ptr_reg + PW'(1);
        fifo2_out_reg <= mem2[r2_ptr_reg[ADDR_W-1:0]];
      end
      if (a_edge) begin
        w2_at_a_reg <= w2_ptr_reg;
      end
      if (b_edge) begin
        r2_at_b_reg <= r2_ptr_reg;
      end
    end
  end

  // fill levels seen by each flag: own pointer after this edge, other pointer one edge old
  logic [PW-1:0] fill1_b, fill1_a, fill2_a, fill2_b;

  assign fill1_b = w1_at_b_reg - (r1_ptr_reg + PW'(pop1));
  assign fill1_a = (w1_ptr_reg + PW'(push1)) - r1_at_a_reg;
  assign fill2_a = w2_at_a_reg - (r2_ptr_reg + PW'(pop2));
  assign fill2_b = (w2_ptr_reg + PW'(push2)) - r2_at_b_reg;

  // an event just before an edge may miss that edge's capture and land one edge later
  always_ff @(posedge clock) begin
    if (rst || in_reset1) begin
      port_b_near_empty_n <= 1'b0;
      port_a_near_full_n  <= 1'b1;
    end else begin
      if (b_edge) begin
        port_b_near_empty_n <= fill1_b > {1'b0, empty_offset_1_reg};
      end
      if (a_edge) begin
        port_a_near_full_n  <= fill1_a < (DEPTH_CNT - {1'b0, full_offset_1_reg});
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst || in_reset2) begin
      port_a_near_empty_n <= 1'b0;
      port_b_near_full_n  <= 1'b1;
    end else begin
      if (a_edge) begin
        port_a_near_empty_n <= fill2_a > {1'b0, empty_offset_2_reg};
      end
      if (b_edge) begin
        port_b_near_full_n  <= fill2_b < (DEPTH_CNT - {1'b0, full_offset_2_reg});
      end
    end
  end

  // mailboxes: a load in the same cycle as a read leaves the flag low
  logic [`DATA_W-1:0] mail_a_to_b_reg, mail_b_to_a_reg;

  always_ff @(posedge clock) begin
    if (rst || in_reset1) begin
      mail_a_to_b_reg <= '0;
      mail_ab_full_n  <= 1'b1;
    end else if (a_wr && st_reg.a.mail_sel && mail_ab_full_n) begin
      mail_a_to_b_reg <= st_reg.a.data & lane_mask(width_reg);
      mail_ab_full_n  <= 1'b0;
    end else if (b_rd && st_reg.b.mail_sel) begin
      mail_ab_full_n  <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || in_reset2) begin
      mail_b_to_a_reg <= '0;
      mail_ba_full_n  <= 1'b1;
    end else if (b_wr && st_reg.b.mail_sel && mail_ba_full_n) begin
      mail_b_to_a_reg <= st_reg.b.data & lane_mask(width_reg);
      mail_ba_full_n  <= 1'b0;
    end else if (a_rd && st_reg.a.mail_sel) begin
      mail_ba_full_n  <= 1'b1;
    end
  end

  // output buses follow the mail select one clock behind; unused lanes read zero
  always_ff @(posedge clock) begin
    if (rst) begin
      port_a_data_out <= '0;
      port_a_data_oe  <= 1'b0;
      port_b_data_out <= '0;
      port_b_data_oe  <= 1'b0;
    end else begin
      port_a_data_oe  <= ~st_reg.a.select_n & ~st_reg.a.dir;
      port_b_data_oe  <= ~st_reg.b.select_n & st_reg.b.dir;
      port_a_data_out <= st_reg.a.mail_sel ? mail_b_to_a_reg : fifo2_out_reg;
      port_b_data_out <= st_reg.b.mail_sel ? mail_a_to_b_reg : fifo1_out_reg;
    end
  end

endmodule // bififo_core

// *** bififo_core_sva.sv ***
// Purpose: port-level assertions for the fifo flag, mailbox and sizing block
// Assumes: port pins are held 5 clocks either side of each port clock rise
// Notes:   edge detection lags the pin by up to 5 clocks, hence the windows
`timescale 1ns/1ps
module bififo_core_sva (
  // system
  input wire logic clock,
  input wire logic rst,
  // port a
  input wire logic port_a_clk,
  input wire logic port_a_select_n,
  input wire logic port_a_write_not_read,
  input wire logic port_a_transfer_en,
  input wire logic port_a_mail_sel,
  input wire logic port_a_data_oe,
  // port b
  input wire logic port_b_clk,
  input wire logic port_b_select_n,
  input wire logic port_b_read_not_write,
  input wire logic port_b_transfer_en,
  input wire logic port_b_mail_sel,
  input wire logic port_b_data_oe,
  // resets and flags
  input wire logic master_reset_1_n,
  input wire logic master_reset_2_n,
  input wire logic port_a_near_full_n,
  input wire logic port_b_near_empty_n,
  input wire logic mail_ab_full_n,
  input wire logic mail_ba_full_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  logic       a_go;
  logic       b_go;
  logic       mr_n;
  logic [3:0] a_age_reg;
  logic [3:0] b_age_reg;

  assign a_go = !port_a_select_n && port_a_transfer_en && port_a_mail_sel;
  assign b_go = !port_b_select_n && port_b_transfer_en && port_b_mail_sel;
  assign mr_n = master_reset_1_n && master_reset_2_n;

  // clocks since each port clock was last high
  always_ff @(posedge clock) begin
    if (rst) begin
      a_age_reg <= 4'hF;
      b_age_reg <= 4'hF;
    end else begin
      a_age_reg <= port_a_clk ? 4'h0 : a_age_reg + {3'h0, a_age_reg != 4'hF};
      b_age_reg <= port_b_clk ? 4'h0 : b_age_reg + {3'h0, b_age_reg != 4'hF};
    end
  end

  reset_state_a: assert property (disable iff (1'b0) rst |=>
      mail_ab_full_n && mail_ba_full_n && !port_b_near_empty_n && port_a_near_full_n)
    else $error("flags not at reset values");
  ab_load_a: assert property ($rose(port_a_clk) && a_go && port_a_write_not_read
      |-> ##[3:9] !mail_ab_full_n) else $error("a-to-b mail flag did not fall");
  ab_read_a: assert property ($rose(port_b_clk) && b_go && port_b_read_not_write
      |-> ##[3:9] mail_ab_full_n) else $error("a-to-b mail flag did not rise");
  ba_load_a: assert property ($rose(port_b_clk) && b_go && !port_b_read_not_write
      |-> ##[3:9] !mail_ba_full_n) else $error("b-to-a mail flag did not fall");
  ba_read_a: assert property ($rose(port_a_clk) && a_go && !port_a_write_not_read
      |-> ##[3:9] mail_ba_full_n) else $error("b-to-a mail flag did not rise");
  ab_cause_a: assert property ($fell(mail_ab_full_n) |-> a_go && port_a_write_not_read)
    else $error("a-to-b mail flag fell without a mail write");
  ba_cause_a: assert property ($fell(mail_ba_full_n) |-> b_go && !port_b_read_not_write)
    else $error("b-to-a mail flag fell without a mail write");
  b_oe_on_a: assert property ((!port_b_select_n && port_b_read_not_write) [*8]
      |=> port_b_data_oe) else $error("port b output not enabled while reading");
  a_oe_off_a: assert property (port_a_select_n [*8] |=> !port_a_data_oe)
    else $error("port a output enabled while deselected");
  b_empty_sync_a: assert property ($changed(port_b_near_empty_n)
      |-> b_age_reg < 4'h4 || !mr_n) else $error("port b near-empty moved off its clock");
  a_full_sync_a: assert property ($changed(port_a_near_full_n)
      |-> a_age_reg < 4'h4 || !mr_n) else $error("port a near-full moved off its clock");

  mail_pass_c: cover property ($fell(mail_ab_full_n) ##[1:300] $rose(mail_ab_full_n));
  near_empty_c: cover property ($rose(port_b_near_empty_n));
  near_full_c: cover property ($fell(port_a_near_full_n));
endmodule // bififo_core_sva

bind bififo_core bififo_core_sva bififo_core_sva_inst (.*);

// *** port_host.sv ***
// Purpose: behavioural host on one fifo port, making its port clock and pins
// Assumes: pins are oversampled on clock, so each phase lasts 6 clocks
// Notes:   idle data lines carry the inverse of the last value
`timescale 1ns/1ps
module port_host #(
  parameter logic WR_LEVEL = 1'b1
) (
  // system
  input  wire logic        clock,
  // port pins
  output logic             port_clk,
  output logic             select_n,
  output logic             dir,
  output logic             en,
  output logic             mail_sel,
  output logic [35:0]      data
);
  initial begin
    port_clk = 1'b0;
    select_n = 1'b1;
    dir = ~WR_LEVEL;
    en = 1'b0;
    mail_sel = 1'b0;
    data = 36'h0;
  end

  // one port clock period; the clock stands still between calls
  task automatic cycle(input logic act, input logic wr, input logic mail, input logic [35:0] d);
    @(posedge clock);
    select_n <= ~act;
    en <= act;
    dir <= wr ? WR_LEVEL : ~WR_LEVEL;
    mail_sel <= mail;
    data <= (act && wr) ? d : ~data;
    repeat (6) @(posedge clock);
    port_clk <= 1'b1;
    repeat (6) @(posedge clock);
    port_clk <= 1'b0;
    repeat (6) @(posedge clock);
    select_n <= 1'b1;
    en <= 1'b0;
  endtask
endmodule // port_host

// *** bidir_fifo_flags_mailbox_sizing_test.sv ***
// Purpose: self-checking bench for the fifo flag, mailbox and port b sizing block
// Assumes: offsets sit at their preset; hosts drive all port pins
// Notes:   depth cut to 32 so the almost-full walk stays short
`include "bififo_defines.svh"
`timescale 1ns/1ps
module bidir_fifo_flags_mailbox_sizing_test;
  localparam int ADDR_W = 5;
  localparam int DEPTH  = 1 << ADDR_W;
  localparam int OFS    = `OFFSET_PRESET;
  localparam int LIMIT  = 20000;

  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        width_match_sel = 1'b0;
  logic        size_sel = 1'b0;
  logic        msb_first_sel = 1'b0;
  logic        master_reset_1_n = 1'b1;
  logic        master_reset_2_n = 1'b1;
  logic        port_a_clk, port_a_select_n, port_a_write_not_read, port_a_transfer_en;
  logic        port_a_mail_sel, port_a_data_oe, port_b_clk, port_b_select_n;
  logic        port_b_read_not_write, port_b_transfer_en, port_b_mail_sel, port_b_data_oe;
  logic        port_a_near_empty_n, port_a_near_full_n, port_b_near_empty_n, port_b_near_full_n;
  logic        mail_ab_full_n, mail_ba_full_n;
  logic [35:0] port_a_data_in, port_a_data_out, port_b_data_in, port_b_data_out;
  logic [31:0] seed = 32'h0000004F;
  logic [35:0] q[$];
  int          nt[5] = '{1, 2, 2, 4, 4};
  int          cycles = 0;
  int          n_fail = 0;
  int          check_count = 0;

  port_host #(.WR_LEVEL(1'b1)) a_host (.clock, .port_clk(port_a_clk), .select_n(port_a_select_n),
    .dir(port_a_write_not_read), .en(port_a_transfer_en), .mail_sel(port_a_mail_sel),
    .data(port_a_data_in));
  port_host #(.WR_LEVEL(1'b0)) b_host (.clock, .port_clk(port_b_clk), .select_n(port_b_select_n),
    .dir(port_b_read_not_write), .en(port_b_transfer_en), .mail_sel(port_b_mail_sel),
    .data(port_b_data_in));
  bififo_core #(.ADDR_W(ADDR_W)) bififo_core_inst (.clock, .rst, .port_a_clk, .port_a_select_n,
    .port_a_write_not_read, .port_a_transfer_en, .port_a_mail_sel, .port_a_data_in,
    .port_a_data_out, .port_a_data_oe, .port_b_clk, .port_b_select_n, .port_b_read_not_write,
    .port_b_transfer_en, .port_b_mail_sel, .port_b_data_in, .port_b_data_out, .port_b_data_oe,
    .width_match_sel, .size_sel, .msb_first_sel, .master_reset_1_n, .master_reset_2_n,
    .port_a_near_empty_n, .port_a_near_full_n, .port_b_near_empty_n, .port_b_near_full_n,
    .mail_ab_full_n, .mail_ba_full_n);

  initial begin
    forever #50 clock = ~clock;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [35:0] rnd36();
    logic [63:0] v;
    v = {xs(), xs()};
    return v[35:0];
  endfunction

  // piece k of n from a long word, in transfer order
  function automatic logic [35:0] piece(input logic [35:0] w, input int k, input int n,
                                        input logic msb);
    int wd;
    int sh;
    wd = 36 / n;
    sh = msb ? (n - 1 - k) * wd : k * wd;
    return (w >> sh) & ((36'h1 << wd) - 36'h1);
  endfunction

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic read_b();
    b_host.cycle(1'b1, 1'b0, 1'b0, 36'h0);
    check(port_b_data_out, q.pop_front());
  endtask

  // sizes change only across a master reset
  task automatic master_reset(input int n, input logic msb);
    @(posedge clock);
    master_reset_1_n <= 1'b0;
    master_reset_2_n <= 1'b0;
    width_match_sel <= (n != 1);
    size_sel <= (n == 4);
    msb_first_sel <= msb;
    repeat (10) @(posedge clock);
    master_reset_1_n <= 1'b1;
    master_reset_2_n <= 1'b1;
    repeat (12) @(posedge clock);
  endtask

  task automatic mail_round(input int n);
    logic [35:0] d1;
    logic [35:0] d2;
    logic [35:0] m;
    d1 = rnd36();
    d2 = rnd36();
    m = piece('1, 0, n, 1'b0);
    a_host.cycle(1'b1, 1'b1, 1'b1, d1);
    check(36'(mail_ab_full_n), 36'h0);
    a_host.cycle(1'b1, 1'b1, 1'b1, d2);
    b_host.cycle(1'b1, 1'b0, 1'b1, 36'h0);
    check(port_b_data_out & m, d1 & m);
    check(36'(mail_ab_full_n), 36'h1);
    b_host.cycle(1'b1, 1'b0, 1'b1, 36'h0);
    check(port_b_data_out & m, d1 & m);
    b_host.cycle(1'b1, 1'b1, 1'b1, d2);
    check(36'(mail_ba_full_n), 36'h0);
    a_host.cycle(1'b1, 1'b0, 1'b1, 36'h0);
    check(port_a_data_out & m, d2 & m);
    check(36'(mail_ba_full_n), 36'h1);
  endtask

  task automatic sized_round(input int n, input logic msb);
    logic [35:0] wa;
    logic [35:0] wb;
    logic [35:0] m;
    wa = rnd36();
    wb = rnd36();
    m = piece('1, 0, n, 1'b0);
    a_host.cycle(1'b1, 1'b1, 1'b0, wa);
    for (int k = 0; k < n; k++) begin
      b_host.cycle(1'b1, 1'b1, 1'b0, (rnd36() & ~m) | piece(wb, k, n, msb));
    end
    for (int k = 0; k < 2; k++) begin
      b_host.cycle(1'b0, 1'b0, 1'b0, 36'h0);
      a_host.cycle(1'b0, 1'b0, 1'b0, 36'h0);
    end
    check(36'(port_a_near_empty_n), 36'h0);
    check(36'(port_b_near_full_n), 36'h1);
    for (int k = 0; k < n; k++) begin
      b_host.cycle(1'b1, 1'b0, 1'b0, 36'h0);
      check(port_b_data_out & m, piece(wa, k, n, msb));
    end
    a_host.cycle(1'b1, 1'b0, 1'b0, 36'h0);
    check(port_a_data_out, wb);
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    logic [35:0] w;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    check(36'(port_b_near_empty_n), 36'h0);
    check(36'(port_a_near_full_n), 36'h1);
    mail_round(1);
    $display("test reset and mail finished");
    for (int i = 0; i < DEPTH - OFS; i++) begin
      if (i == DEPTH - OFS - 1) begin
        a_host.cycle(1'b0, 1'b0, 1'b0, 36'h0);
        check(36'(port_a_near_full_n), 36'h1);
      end
      w = rnd36();
      q.push_back(w);
      a_host.cycle(1'b1, 1'b1, 1'b0, w);
    end
    a_host.cycle(1'b0, 1'b0, 1'b0, 36'h0);
    check(36'(port_a_near_full_n), 36'h0);
    b_host.cycle(1'b0, 1'b0, 1'b0, 36'h0);
    check(36'(port_b_near_empty_n), 36'h0);
    b_host.cycle(1'b0, 1'b0, 1'b0, 36'h0);
    check(36'(port_b_near_empty_n), 36'h1);
    read_b();
    a_host.cycle(1'b0, 1'b0, 1'b0, 36'h0);
    check(36'(port_a_near_full_n), 36'h0);
    a_host.cycle(1'b0, 1'b0, 1'b0, 36'h0);
    check(36'(port_a_near_full_n), 36'h1);
    while (q.size() > OFS + 1) begin
      read_b();
    end
    b_host.cycle(1'b0, 1'b0, 1'b0, 36'h0);
    check(36'(port_b_near_empty_n), 36'h1);
    read_b();
    b_host.cycle(1'b0, 1'b0, 1'b0, 36'h0);
    check(36'(port_b_near_empty_n), 36'h0);
    while (q.size() > 0) begin
      read_b();
    end
    $display("test flags finished");
    for (int i = 0; i < 5; i++) begin
      master_reset(nt[i], i[0]);
      mail_round(nt[i]);
      sized_round(nt[i], i[0]);
      $display("test sizing %0d pieces finished", nt[i]);
    end
    test_done();
  end
endmodule // bidir_fifo_flags_mailbox_sizing_test
